// [rtl/scd_cmd_chain.sv]
// serial command decoder with daisy-chain output shifter
`timescale 1ns/1ps
module scd_cmd_chain (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic chain_in,
	input wire logic conv_done,
	input scd_pkg::scd_frame_t frame_in,
	output logic dout,
	output logic conversion_ready_n,
	output logic converting,
	output logic cont_read,
	output logic standby,
	output logic reset_busy,
	output logic filter_restart
);
	scd_pkg::scd_pins_t pins;
	scd_pkg::scd_state_t state;
	logic [7:0] regs [0:31];
	logic [2:0] byte_bits;
	logic [6:0] byte_sr;
	logic is_read;
	logic [4:0] addr;
	logic [4:0] left;
	logic stop_pending;
	logic [4:0] rst_cnt;
	logic [scd_pkg::FRAME_W-1:0] frame_hold;
	logic [scd_pkg::FRAME_W-1:0] out_sr;
	logic out_is_data;
	logic chain_en;
	logic sel;
	logic fall7;
	logic fall8;
	logic [7:0] op7;
	logic [7:0] op8;
	logic accept;
	logic do_wake;
	logic do_standby;
	logic do_reset;
	logic do_start;
	logic do_stop;
	logic do_single;
	logic do_cont;
	logic do_cont_stop;
	logic rd_first;
	logic wr_first;
	logic rd_load;
	logic wr_store;
	logic cfg1_change;
	logic frame_take;
	logic fill_bit;

	// power-on and reset-opcode contents of each register
	function automatic logic [7:0] reg_default(input logic [4:0] a);
		if (a == scd_pkg::ADDR_ID) begin
			return scd_pkg::RST_ID;
		end else if (a == scd_pkg::ADDR_CONFIG_REG_ONE) begin
			return scd_pkg::RST_CONFIG_REG_ONE;
		end else if (a == scd_pkg::ADDR_CONFIG2) begin
			return scd_pkg::RST_CONFIG2;
		end else if (a == scd_pkg::ADDR_CONFIG3) begin
			return scd_pkg::RST_CONFIG3;
		end else if (a >= scd_pkg::ADDR_CH_FIRST && a <= scd_pkg::ADDR_CH_LAST) begin
			return scd_pkg::RST_CHSET;
		end
		return scd_pkg::RST_OTHER;
	endfunction

	// identity and fault status stay read-only
	function automatic logic reg_writable(input logic [4:0] a);
		return a != scd_pkg::ADDR_ID && a != scd_pkg::ADDR_FAULT_P
			&& a != scd_pkg::ADDR_FAULT_N;
	endfunction

	scd_pin_sync scd_pin_sync_inst (
		.clk(clk),
		.rst_n(rst_n),
		.sclk(sclk),
		.cs_n(cs_n),
		.din(din),
		.chain_in(chain_in),
		.pins(pins)
	);

	// byte framing: fall count and the bits gathered so far
	assign sel = ~pins.cs_n;
	assign fall7 = sel & pins.sclk_fall & (byte_bits == 3'h6);
	assign fall8 = sel & pins.sclk_fall & (byte_bits == 3'h7);
	assign op7 = {byte_sr[5:0], pins.din, 1'b0};
	assign op8 = {byte_sr[6:0], pins.din};
	assign chain_en = regs[scd_pkg::ADDR_CONFIG_REG_ONE][scd_pkg::CFG1_CHAIN_BIT];

	// opcode decode; during reset completion nothing is taken
	always_comb begin
		accept = (state == scd_pkg::SCD_OPCODE) && !reset_busy;
		do_wake = accept && fall7 && op7 == scd_pkg::OP_WAKE;
		// standby only listens for wake
		accept = accept && !standby;
		do_standby = accept && fall7 && op7 == scd_pkg::OP_STANDBY;
		do_reset = accept && fall7 && op7 == scd_pkg::OP_RESET;
		do_start = accept && fall7 && op7 == scd_pkg::OP_START;
		do_stop = accept && fall7 && op7 == scd_pkg::OP_STOP;
		do_single = accept && fall7 && op7 == scd_pkg::OP_SINGLE_READ;
		do_cont = accept && fall8 && op8 == scd_pkg::OP_CONT_READ;
		do_cont_stop = accept && fall8 && op8 == scd_pkg::OP_CONT_READ_STOP;
		rd_first = accept && fall8 && op8[7:5] == scd_pkg::OP_REG_READ && !cont_read;
		wr_first = accept && fall8 && op8[7:5] == scd_pkg::OP_REG_WRITE;
		rd_load = fall8 && ((state == scd_pkg::SCD_COUNT && is_read)
			|| (state == scd_pkg::SCD_RD_DATA && left != 5'h00));
		wr_store = fall8 && state == scd_pkg::SCD_WR_DATA;
		cfg1_change = wr_store && addr == scd_pkg::ADDR_CONFIG_REG_ONE
			&& op8 != regs[scd_pkg::ADDR_CONFIG_REG_ONE];
	end

	// bit counter restarts whenever chip select goes high
	always_ff @(posedge clk) begin
		if (!rst_n || pins.cs_n) begin
			byte_bits <= 3'h0;
			byte_sr <= 7'h00;
		end else if (pins.sclk_fall) begin
			byte_bits <= byte_bits + 3'h1;
			byte_sr <= op8[6:0];
		end
	end

	// multibyte sequencer; other bytes fall through as no-ops
	always_ff @(posedge clk) begin
		if (!rst_n || pins.cs_n) begin
			state <= scd_pkg::SCD_OPCODE;
			is_read <= 1'b0;
			addr <= 5'h00;
			left <= 5'h00;
		end else begin
			case (state)
				scd_pkg::SCD_OPCODE: begin
					if (rd_first || wr_first) begin
						state <= scd_pkg::SCD_COUNT;
						is_read <= rd_first;
						addr <= op8[4:0];
					end
				end
				scd_pkg::SCD_COUNT: begin
					if (fall8) begin
						// count byte carries registers minus one
						left <= op8[4:0];
						state <= is_read ? scd_pkg::SCD_RD_DATA : scd_pkg::SCD_WR_DATA;
						addr <= is_read ? addr + 5'h01 : addr;
					end
				end
				scd_pkg::SCD_RD_DATA: begin
					if (fall8) begin
						if (left == 5'h00) begin
							state <= scd_pkg::SCD_OPCODE;
						end else begin
							left <= left - 5'h01;
							addr <= addr + 5'h01;
						end
					end
				end
				scd_pkg::SCD_WR_DATA: begin
					if (fall8) begin
						addr <= addr + 5'h01;
						if (left == 5'h00) begin
							state <= scd_pkg::SCD_OPCODE;
						end else begin
							left <= left - 5'h01;
						end
					end
				end
				default: begin
					state <= scd_pkg::SCD_OPCODE;
				end
			endcase
		end
	end

	// register file; the reset opcode reloads every default
	always_ff @(posedge clk) begin
		if (!rst_n || do_reset) begin
			for (int i = 0; i < 32; i++) begin
				regs[i] <= reg_default(5'(i));
			end
		end else if (wr_store && reg_writable(addr)) begin
			regs[addr] <= op8;
		end
	end

	// mode flags: continuous read from power-up, standby by opcode
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cont_read <= 1'b1;
			standby <= 1'b0;
		end else begin
			if (do_cont || do_reset) begin
				cont_read <= 1'b1;
			end else if (do_cont_stop) begin
				cont_read <= 1'b0;
			end
			if (do_standby) begin
				standby <= 1'b1;
			end else if (do_wake) begin
				standby <= 1'b0;
			end
		end
	end

	// conversion run control; stop waits for the frame in flight
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			converting <= 1'b0;
			stop_pending <= 1'b0;
		end else begin
			if (do_start) begin
				converting <= 1'b1;
			end else if (conv_done && stop_pending) begin
				converting <= 1'b0;
			end
			if (do_stop && converting) begin
				stop_pending <= 1'b1;
			end else if (conv_done || !converting) begin
				stop_pending <= 1'b0;
			end
		end
	end

	// reset completion timer and filter restart pulse
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rst_cnt <= 5'h00;
			reset_busy <= 1'b0;
			filter_restart <= 1'b0;
		end else begin
			filter_restart <= do_reset | cfg1_change;
			if (do_reset) begin
				rst_cnt <= scd_pkg::RESET_CYCLES;
				reset_busy <= 1'b1;
			end else if (rst_cnt != 5'h00) begin
				rst_cnt <= rst_cnt - 5'h01;
				reset_busy <= rst_cnt != 5'h01;
			end
		end
	end

	// latest result kept for single reads
	assign frame_take = conv_done && converting && !standby;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			frame_hold <= '0;
		end else if (frame_take) begin
			frame_hold <= frame_in;
		end
	end

	// ready goes low on a new result; a result in the same cycle wins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			conversion_ready_n <= 1'b1;
		end else if (frame_take) begin
			conversion_ready_n <= 1'b0;
		end else if ((sel && pins.sclk_fall) || do_start) begin
			conversion_ready_n <= 1'b1;
		end
	end

	// behind a data frame chain mode feeds the far device in, else data recirculates; register reads fill zeros
	always_comb begin
		if (!out_is_data) begin
			fill_bit = 1'b0;
		end else if (chain_en) begin
			fill_bit = pins.chain_in;
		end else begin
			fill_bit = out_sr[scd_pkg::FRAME_W-1];
		end
	end

	// output shifter; loads win over a shift in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_sr <= '0;
			out_is_data <= 1'b0;
			dout <= 1'b0;
		end else begin
			if (rd_load) begin
				out_sr <= {regs[addr], {(scd_pkg::FRAME_W-8){1'b0}}};
				out_is_data <= 1'b0;
			end else if (do_single) begin
				out_sr <= frame_hold;
				out_is_data <= 1'b1;
			end else if (frame_take && cont_read) begin
				out_sr <= frame_in;
				out_is_data <= 1'b1;
			end else if (sel && pins.sclk_rise) begin
				// synced chain level is still the pre-edge bit: the spare bit
				out_sr <= {out_sr[scd_pkg::FRAME_W-2:0], fill_bit};
			end
			if (sel && pins.sclk_rise) begin
				dout <= out_sr[scd_pkg::FRAME_W-1];
			end
		end
	end
endmodule // scd_cmd_chain

// [common/scd_pkg.sv]
// constants, types and opcodes shared by the serial command decoder
package scd_pkg;

	// clock rates; clk doubles as the converter master clock
	localparam int CLK_PERIOD_NS = 100;
	localparam int MCLK_PERIOD_NS = 100;

	// reset opcode completion time in master clock periods, then in clk cycles
	localparam int RESET_MASTER_PERIODS = 18;
	localparam int RESET_CYCLES_I =
		(RESET_MASTER_PERIODS * MCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] RESET_CYCLES = 5'(RESET_CYCLES_I);

	// system and data opcodes
	localparam logic [7:0] OP_WAKE = 8'h02;
	localparam logic [7:0] OP_STANDBY = 8'h04;
	localparam logic [7:0] OP_RESET = 8'h06;
	localparam logic [7:0] OP_START = 8'h08;
	localparam logic [7:0] OP_STOP = 8'h0A;
	localparam logic [7:0] OP_CONT_READ = 8'h10;
	localparam logic [7:0] OP_CONT_READ_STOP = 8'h11;
	localparam logic [7:0] OP_SINGLE_READ = 8'h12;

	// register access opcodes: top three bits of each byte
	localparam logic [2:0] OP_REG_READ = 3'h1;
	localparam logic [2:0] OP_REG_WRITE = 3'h2;
	localparam logic [2:0] OP_COUNT_PREFIX = 3'h0;

	// register addresses
	localparam logic [4:0] ADDR_ID = 5'h00;
	localparam logic [4:0] ADDR_CONFIG_REG_ONE = 5'h01;
	localparam logic [4:0] ADDR_CONFIG2 = 5'h02;
	localparam logic [4:0] ADDR_CONFIG3 = 5'h03;
	localparam logic [4:0] ADDR_CH_FIRST = 5'h05;
	localparam logic [4:0] ADDR_CH_LAST = 5'h0C;
	localparam logic [4:0] ADDR_FAULT_P = 5'h12;
	localparam logic [4:0] ADDR_FAULT_N = 5'h13;

	// reset values; the identity value is arbitrary
	localparam logic [7:0] RST_ID = 8'hA5;
	localparam logic [7:0] RST_CONFIG_REG_ONE = 8'h01;
	localparam logic [7:0] RST_CONFIG2 = 8'h60;
	localparam logic [7:0] RST_CONFIG3 = 8'h40;
	localparam logic [7:0] RST_CHSET = 8'h10;
	localparam logic [7:0] RST_OTHER = 8'h00;

	// chain-input enable bit in configuration register one
	localparam int CFG1_CHAIN_BIT = 6;

	// output frame: 24-bit status then eight 16-bit channel words
	localparam int NUM_CH = 8;
	localparam int FRAME_W = 152;

	typedef struct packed {
		logic [23:0] status;
		logic [NUM_CH-1:0][15:0] chan;
	} scd_frame_t;

	// serial pins after synchronisation, with sclk edge pulses
	typedef struct packed {
		logic sclk_rise;
		logic sclk_fall;
		logic cs_n;
		logic din;
		logic chain_in;
	} scd_pins_t;

	// byte sequencer states
	typedef enum logic [1:0] {
		SCD_OPCODE = 2'b00,
		SCD_COUNT = 2'b01,
		SCD_WR_DATA = 2'b10,
		SCD_RD_DATA = 2'b11
	} scd_state_t;

endpackage

// [rtl/scd_pin_sync.sv]
// two-flop synchronisers for the serial pins and sclk edge finder
`timescale 1ns/1ps
module scd_pin_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic chain_in,
	output scd_pkg::scd_pins_t pins
);
	logic [3:0] raw;
	logic [3:0] meta;
	logic [3:0] stable;
	logic sclk_prev;

	assign raw = {sclk, cs_n, din, chain_in};

	// one synchroniser per pin; meta feeds only the second stage
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sync
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					meta[g] <= (g == 2) ? 1'b1 : 1'b0;
					stable[g] <= (g == 2) ? 1'b1 : 1'b0;
				end else begin
					meta[g] <= raw[g];
					stable[g] <= meta[g];
				end
			end
		end
	endgenerate

	// third stage of sclk, used only for edge detection
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclk_prev <= 1'b0;
		end else begin
			sclk_prev <= stable[3];
		end
	end

	assign pins.sclk_rise = stable[3] & ~sclk_prev;
	assign pins.sclk_fall = ~stable[3] & sclk_prev;
	assign pins.cs_n = stable[2];
	assign pins.din = stable[1];
	assign pins.chain_in = stable[0];
endmodule // scd_pin_sync

// [test/scd_cmd_chain_assertions.sv]
// port-level checker for the serial command decoder
`timescale 1ns/1ps
module scd_cmd_chain_assertions (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic chain_in,
	input wire logic conv_done,
	input scd_pkg::scd_frame_t frame_in,
	input wire logic dout,
	input wire logic conversion_ready_n,
	input wire logic converting,
	input wire logic cont_read,
	input wire logic standby,
	input wire logic reset_busy,
	input wire logic filter_restart
);
	logic [4:0] busy_cnt;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// length of the busy stretch so far; wraps if busy sticks, and a busy that never falls never trips the check below
	always_ff @(posedge clk) begin
		if (!rst_n || !reset_busy) begin
			busy_cnt <= 5'h00;
		end else begin
			busy_cnt <= busy_cnt + 5'h01;
		end
	end

	chk_busy_length: assert property ($fell(reset_busy) |-> busy_cnt == 5'h12)
		else $error("busy stretch not eighteen cycles");
	chk_reset_restart: assert property ($rose(reset_busy) |-> filter_restart)
		else $error("reset opcode without filter restart");
	chk_restart_pulse: assert property (filter_restart |=> !filter_restart)
		else $error("filter restart longer than one cycle");
	chk_dout_on_rise: assert property ($changed(dout) |-> $past(sclk) || $past(sclk, 2))
		else $error("dout moved away from a clock rise");
	chk_ready_release: assert property (
		$fell(sclk) && !cs_n |-> ##[1:6] (conversion_ready_n || conv_done))
		else $error("ready flag not released after clock fall");
	chk_ready_frame: assert property (
		conv_done && converting && !standby |=> !conversion_ready_n)
		else $error("new result did not lower ready flag");
	chk_stop_at_frame: assert property ($fell(converting) |-> $past(conv_done))
		else $error("conversions stopped mid conversion");
	chk_standby_refuse: assert property ($rose(converting) |-> !$past(standby))
		else $error("start accepted in standby");

	// main scenarios reached
	cover property ($rose(reset_busy));
	cover property (conv_done && converting ##1 !conversion_ready_n);
	cover property ($rose(standby));
endmodule // scd_cmd_chain_assertions

// [test/scd_host_model.sv]
// host controller model on the serial pins, plus a downstream chain device
`timescale 1ns/1ps
module scd_host_model #(
	parameter logic [151:0] DOWN_FRAME = 152'h0
) (
	input wire logic clk,
	input wire logic dout,
	output logic sclk,
	output logic cs_n,
	output logic din,
	output logic chain_in
);
	int cnt;

	// idle: clock parked low, device deselected
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
		chain_in = 1'b0;
		cnt = 0;
	end

	// select; downstream output sits low ahead of its first bit
	task automatic sel();
		@(negedge clk);
		cs_n = 1'b0;
		chain_in = 1'b0;
		cnt = 0;
		repeat (4) @(negedge clk);
	endtask

	// msb first; din moves with the rise, dout read just before the next rise
	task automatic shift(input int n, input logic [511:0] tx, output logic [511:0] rx);
		rx = 512'h0;
		for (int i = n - 1; i >= 0; i--) begin
			din = tx[i];
			sclk = 1'b1;
			cnt++;
			repeat (3) @(negedge clk);
			// downstream clock-to-out delay keeps the old bit at the sampling rise
			chain_in = (cnt <= 152) ? DOWN_FRAME[152 - cnt] : ~chain_in;
			@(negedge clk);
			sclk = 1'b0;
			repeat (4) @(negedge clk);
			rx[i] = dout;
		end
	endtask

	// released lines flip so a stale level never passes for data
	task automatic desel();
		repeat (8) @(negedge clk);
		cs_n = 1'b1;
		din = ~din;
		chain_in = ~chain_in;
		repeat (20) @(negedge clk);
	endtask
endmodule // scd_host_model

// [test/tb_scd_cmd_chain.sv]
// self-checking bench for the serial command decoder and chain shifter
`timescale 1ns/1ps
module tb_scd_cmd_chain;
	localparam logic [151:0] FR_A = 152'hC3A5F0_0123456789ABCDEF_FEDCBA9876543210;
	localparam logic [151:0] FR_B = 152'hDA0F3C_13579BDF02468ACE_0F1E2D3C4B5A6978;
	localparam logic [151:0] DOWN = 152'h96E1B4_AAAA5555CCCC3333_00FF00FF0F0F0F0F;
	localparam logic [7:0] CFG_CHAIN = scd_pkg::RST_CONFIG_REG_ONE
		| (8'h01 << scd_pkg::CFG1_CHAIN_BIT);
	localparam logic [15:0] CFG_DEFAULTS = {scd_pkg::RST_CONFIG_REG_ONE, scd_pkg::RST_CONFIG2};

	logic clk, rst_n, sclk, cs_n, din, chain_in, conv_done;
	scd_pkg::scd_frame_t frame_in;
	logic dout, conversion_ready_n, converting, cont_read, standby, reset_busy, filter_restart;
	logic [511:0] rx;
	int num_errors, total_checks, busy_total, restart_total;

	scd_cmd_chain scd_cmd_chain_inst (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
		.din(din), .chain_in(chain_in), .conv_done(conv_done), .frame_in(frame_in), .dout(dout),
		.conversion_ready_n(conversion_ready_n), .converting(converting), .cont_read(cont_read),
		.standby(standby), .reset_busy(reset_busy), .filter_restart(filter_restart));
	scd_host_model #(.DOWN_FRAME(DOWN)) scd_host_model_inst (.clk(clk), .dout(dout),
		.sclk(sclk), .cs_n(cs_n), .din(din), .chain_in(chain_in));

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// cycles spent busy and filter restart pulses seen
	always @(negedge clk) begin
		if (reset_busy === 1'b1) busy_total++;
		if (filter_restart === 1'b1) restart_total++;
	end

	task automatic check(input logic [151:0] seen, input logic [151:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cmd(input logic [7:0] op);
		scd_host_model_inst.sel();
		scd_host_model_inst.shift(8, {504'h0, op}, rx);
		scd_host_model_inst.desel();
	endtask

	// two registers from addr land in rx[15:0]
	task automatic rd(input logic [4:0] addr);
		scd_host_model_inst.sel();
		scd_host_model_inst.shift(32, {480'h0, scd_pkg::OP_REG_READ, addr,
			scd_pkg::OP_COUNT_PREFIX, 5'h01, 16'h0000}, rx);
		scd_host_model_inst.desel();
	endtask

	task automatic new_frame(input logic [151:0] f);
		@(negedge clk);
		frame_in = f;
		conv_done = 1'b1;
		@(negedge clk);
		conv_done = 1'b0;
	endtask

	// bounded wait; a flag that never drops ends the run
	task automatic wait_ready();
		for (int i = 0; i < 20 && conversion_ready_n !== 1'b0; i++) @(negedge clk);
		check(conversion_ready_n, 1'b0, "ready flag");
		if (conversion_ready_n !== 1'b0) report_and_stop();
	endtask

	task automatic t_reset_state();
		check({dout, conversion_ready_n, converting}, 3'h2, "outputs after reset");
		check({cont_read, standby, reset_busy}, 3'h4, "modes after reset");
	endtask

	// start decoded at the seventh fall, before the last bit is sent
	task automatic t_start_stop();
		cmd(scd_pkg::OP_CONT_READ_STOP);
		check(cont_read, 1'b0, "continuous read off");
		scd_host_model_inst.sel();
		scd_host_model_inst.shift(7, 512'h04, rx);
		repeat (4) @(negedge clk);
		check(converting, 1'b1, "start after seventh fall");
		scd_host_model_inst.shift(1, 512'h0, rx);
		scd_host_model_inst.desel();
		cmd(scd_pkg::OP_START);
		check(converting, 1'b1, "start while running");
		cmd(scd_pkg::OP_STOP);
		check(converting, 1'b1, "stop waits for frame");
		new_frame(FR_B);
		wait_ready();
		check(converting, 1'b0, "stopped after frame");
		cmd(scd_pkg::OP_STOP);
		check(converting, 1'b0, "stop while stopped");
	endtask

	// start is sent in standby on purpose, to be refused
	task automatic t_standby();
		cmd(scd_pkg::OP_STANDBY);
		check(standby, 1'b1, "standby entry");
		cmd(scd_pkg::OP_START);
		check(converting, 1'b0, "start refused");
		cmd(scd_pkg::OP_WAKE);
		check(standby, 1'b0, "wake");
		cmd(8'h0C);
		cmd(8'hFF);
		check({converting, cont_read, standby}, 3'h0, "unknown bytes");
	endtask

	task automatic t_registers();
		int r0;
		rd(scd_pkg::ADDR_CONFIG_REG_ONE);
		check(rx[15:0], CFG_DEFAULTS, "default read");
		r0 = restart_total;
		scd_host_model_inst.sel();
		scd_host_model_inst.shift(24, {488'h0, scd_pkg::OP_REG_WRITE,
			scd_pkg::ADDR_CONFIG_REG_ONE, scd_pkg::OP_COUNT_PREFIX, 5'h00, CFG_CHAIN}, rx);
		scd_host_model_inst.desel();
		check(restart_total - r0, 1, "filter restart on config change");
		rd(scd_pkg::ADDR_CONFIG_REG_ONE);
		check(rx[15:0], {CFG_CHAIN, scd_pkg::RST_CONFIG2}, "written read");
		cmd(scd_pkg::OP_CONT_READ);
		check(cont_read, 1'b1, "continuous read on");
		// an honoured read would swallow the trailing stop byte as data
		scd_host_model_inst.sel();
		scd_host_model_inst.shift(24, {488'h0, scd_pkg::OP_REG_READ,
			scd_pkg::ADDR_CONFIG_REG_ONE, scd_pkg::OP_COUNT_PREFIX, 5'h00,
			scd_pkg::OP_CONT_READ_STOP}, rx);
		scd_host_model_inst.desel();
		check(cont_read, 1'b0, "read ignored");
	endtask

	task automatic t_frames();
		cmd(scd_pkg::OP_START);
		new_frame(FR_A);
		wait_ready();
		scd_host_model_inst.sel();
		scd_host_model_inst.shift(159, {353'h0, scd_pkg::OP_SINGLE_READ, 151'h0}, rx);
		scd_host_model_inst.desel();
		check(rx[151:0], FR_A, "single read");
		cmd(scd_pkg::OP_CONT_READ);
		new_frame(FR_B);
		wait_ready();
		scd_host_model_inst.sel();
		scd_host_model_inst.shift(305, 512'h0, rx);
		check(conversion_ready_n, 1'b1, "ready released");
		scd_host_model_inst.desel();
		check(rx[304:153], FR_B, "own frame first");
		check(rx[152], 1'b0, "spare bit, no readback");
		check(rx[151:0], DOWN, "downstream frame");
	endtask

	// leave continuous read first so that the restore below is seen
	task automatic t_reset_cmd();
		int r0;
		cmd(scd_pkg::OP_CONT_READ_STOP);
		busy_total = 0;
		r0 = restart_total;
		cmd(scd_pkg::OP_RESET);
		for (int i = 0; i < 40 && reset_busy !== 1'b0; i++) @(negedge clk);
		check(busy_total, 18, "busy length");
		check(restart_total - r0, 1, "filter restart on reset");
		check(cont_read, 1'b1, "continuous read restored");
		new_frame(FR_A);
		wait_ready();
		scd_host_model_inst.sel();
		scd_host_model_inst.shift(153, 512'h0, rx);
		scd_host_model_inst.desel();
		check(rx[152:1], FR_A, "frame after reset");
		check(rx[0], FR_A[151], "chain input unused");
		cmd(scd_pkg::OP_CONT_READ_STOP);
		rd(scd_pkg::ADDR_CONFIG_REG_ONE);
		check(rx[15:0], CFG_DEFAULTS, "defaults back");
	endtask

	// reset for 16 cycles, then the scenarios in turn
	initial begin
		rst_n = 1'b0;
		conv_done = 1'b0;
		frame_in = '0;
		num_errors = 0;
		total_checks = 0;
		busy_total = 0;
		restart_total = 0;
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_reset_state();
		t_start_stop();
		t_standby();
		t_registers();
		t_frames();
		t_reset_cmd();
		report_and_stop();
	end
endmodule // tb_scd_cmd_chain

bind scd_cmd_chain scd_cmd_chain_assertions chk_inst (.clk(clk), .rst_n(rst_n), .sclk(sclk),
	.cs_n(cs_n), .din(din), .chain_in(chain_in), .conv_done(conv_done), .frame_in(frame_in),
	.dout(dout), .conversion_ready_n(conversion_ready_n), .converting(converting),
	.cont_read(cont_read), .standby(standby), .reset_busy(reset_busy),
	.filter_restart(filter_restart));
